// ===== timer_wave_pkg.sv
// Purpose: constants for the 8-bit timer waveform and clock control block
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes:   register constants are word indices; byte address is four times the index
package timer_wave_pkg;
    // ==========================================================
    // register map, word indices
    localparam logic [7:0] ctrl_a_addr      = 8'hB0;
    localparam logic [7:0] ctrl_b_addr      = 8'hB1;
    localparam logic [7:0] count_addr       = 8'hB2;
    localparam logic [7:0] cmp_a_addr       = 8'hB3;
    localparam logic [7:0] cmp_b_addr       = 8'hB4;
    localparam logic [7:0] src_sel_addr     = 8'hB5;
    localparam logic [7:0] irq_status_addr  = 8'hB8;
    localparam logic [7:0] irq_clear_addr   = 8'hB9;
    localparam logic [7:0] irq_enable_addr  = 8'hBA;
    localparam logic [7:0] ctrl_reset_value = 8'h00;
    // ==========================================================
    // field positions
    localparam int act_a_hi    = 7;
    localparam int act_a_lo    = 6;
    localparam int act_b_hi    = 5;
    localparam int act_b_lo    = 4;
    localparam int force_a_bit = 7;
    localparam int force_b_bit = 6;
    localparam int mode_hi_bit = 3;
    localparam logic [7:0] ctrl_a_rd_mask = 8'hF3;
    localparam logic [7:0] ctrl_b_rd_mask = 8'h0F;
    // ==========================================================
    // counter constants
    localparam logic [7:0] count_max    = 8'hFF;
    localparam logic [7:0] count_bottom = 8'h00;
    localparam logic [2:0] mode_normal  = 3'h0;
    localparam logic [2:0] mode_pc_ff   = 3'h1;
    localparam logic [2:0] mode_ctc     = 3'h2;
    localparam logic [2:0] mode_fast_ff = 3'h3;
    localparam logic [2:0] mode_pc_a    = 3'h5;
    localparam logic [2:0] mode_fast_a  = 3'h7;
    localparam logic [1:0] act_off      = 2'h0;
    localparam logic [1:0] act_toggle   = 2'h1;
    localparam logic [1:0] act_clear    = 2'h2;
    localparam logic [1:0] act_set      = 2'h3;
    localparam int irq_ovf = 0;
    localparam int irq_ma  = 1;
    localparam int irq_mb  = 2;
    localparam int presc_width = 10;
    typedef enum logic [1:0] {
        kind_plain_type_n, kind_fast, kind_phase, kind_reserved
    } kind_type;
endpackage

// ===== timer_wave_ctrl.sv
// Purpose: 8-bit timer waveform generation, force strobes and clock select
// Assumes: single clock hclk; async oscillator input arrives as a pin level
// Notes:   outputs compare_out_a/b are flip-flops; pin enables follow action
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - a nonzero output-B action field lets compare output B drive its pin
// - non-PWM action: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM: 10 clear on match set at bottom, 11 inverse; 01 reserved
// - phase PWM: 10 clear on up-match, set on down-match; 11 inverse
// - fast PWM, compare B at TOP with upper bit: act at bottom only
// - phase PWM, compare at TOP with upper bit: act at TOP instead
// - reserved bits of both control registers read as zero
// - mode bits from both registers pick sequence, TOP source and waveform
// - modes 0,1,3 top 0xFF; 2,5,7 top compare A; 4,6 reserved
// - compare update and overflow flag point depend on the mode
// - force strobes act only in non-PWM modes
// - force strobe gives one immediate match using current action field
// - force strobe raises no flag and never clears the counter
// - force bits are write-only and read back as zero
// - clock select: stop, undivided, or prescaler taps 8 to 1024
// - source clock is hclk unless async select picks the oscillator pin
// - writing the counter blocks compare match on the next timer tick
module timer_wave_ctrl
    import timer_wave_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        osc_pin,
    output logic             compare_out_a,
    output logic             compare_out_b,
    output logic             compare_oe_a,
    output logic             compare_oe_b,
    output logic             irq
);
    // ==========================================================
    // bus slave
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] timer_control_a;
    logic [7:0] timer_control_b;
    logic [7:0] count_value;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic       async_source_select;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;
    logic       force_a;
    logic       force_b;
    logic       count_wr;
    logic       block_match;
    logic       osc_s1;
    logic       osc_s2;
    logic       osc_s3;
    logic [presc_width-1:0] presc;
    logic       tick;
    logic       count_up;
    logic [2:0] mode;
    kind_type   kind;
    logic [7:0] top;
    logic [31:0] next_rdata;
    logic [2:0] ev;
    wire  logic setup = hsel && hready && htrans[1];
    // word index: one register per aligned 32-bit word
    wire  logic [7:0] addr8 = haddr[9:2];
    wire  logic [7:0] wd = hwdata[7:0];
    wire  logic do_wr = wr_pend;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= setup && hwrite;
            if (setup) begin
                wr_addr <= addr8;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (addr8 == ctrl_a_addr) begin
            next_rdata[7:0] = timer_control_a & ctrl_a_rd_mask;
        end else if (addr8 == ctrl_b_addr) begin
            // force bits never stored, reserved zero
            next_rdata[7:0] = timer_control_b & ctrl_b_rd_mask;
        end else if (addr8 == count_addr) begin
            next_rdata[7:0] = count_value;
        end else if (addr8 == cmp_a_addr) begin
            next_rdata[7:0] = buf_a;
        end else if (addr8 == cmp_b_addr) begin
            next_rdata[7:0] = buf_b;
        end else if (addr8 == src_sel_addr) begin
            next_rdata[0] = async_source_select;
        end else if (addr8 == irq_status_addr) begin
            next_rdata[2:0] = irq_status;
        end else if (addr8 == irq_enable_addr) begin
            next_rdata[2:0] = irq_enable;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (setup && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_control_a     <= ctrl_reset_value;
            timer_control_b     <= ctrl_reset_value;
            buf_a               <= 8'h00;
            buf_b               <= 8'h00;
            async_source_select <= 1'b0;
            irq_enable          <= 3'h0;
        end else if (do_wr) begin
            if (wr_addr == ctrl_a_addr) begin
                timer_control_a <= wd & ctrl_a_rd_mask;
            end else if (wr_addr == ctrl_b_addr) begin
                timer_control_b <= wd & ctrl_b_rd_mask;
            end else if (wr_addr == cmp_a_addr) begin
                buf_a <= wd;
            end else if (wr_addr == cmp_b_addr) begin
                buf_b <= wd;
            end else if (wr_addr == src_sel_addr) begin
                async_source_select <= wd[0];
            end else if (wr_addr == irq_enable_addr) begin
                irq_enable <= wd[2:0];
            end
        end
    end

    // one-cycle strobes; force strobes gated off in PWM modes, count_wr never gated
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            force_a  <= 1'b0;
            force_b  <= 1'b0;
            count_wr <= 1'b0;
        end else begin
            force_a  <= do_wr && wr_addr == ctrl_b_addr && wd[force_a_bit]
                        && kind == kind_plain_type_n;
            force_b  <= do_wr && wr_addr == ctrl_b_addr && wd[force_b_bit]
                        && kind == kind_plain_type_n;
            count_wr <= do_wr && wr_addr == count_addr;
        end
    end

    // ==========================================================
    // mode decode
    always_comb begin
        mode = {timer_control_b[mode_hi_bit], timer_control_a[1:0]};
        kind = kind_reserved;
        top  = count_max;
        case (mode)
            mode_normal: kind = kind_plain_type_n;
            mode_ctc: begin
                kind = kind_plain_type_n;
                top  = compare_value_a;
            end
            mode_pc_ff:   kind = kind_phase;
            mode_fast_ff: kind = kind_fast;
            mode_pc_a: begin
                kind = kind_phase;
                top  = compare_value_a;
            end
            mode_fast_a: begin
                kind = kind_fast;
                top  = compare_value_a;
            end
            default: kind = kind_reserved;
        endcase
    end

    // ==========================================================
    // clock source and prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else begin
            osc_s1 <= osc_pin;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    // source tick: every hclk or each rising oscillator edge
    wire logic src_tick = async_source_select ? (osc_s2 && !osc_s3) : 1'b1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc <= '0;
        end else if (src_tick) begin
            presc <= presc + 1'b1;
        end
    end

    // tap fires when the low bits roll over
    always_comb begin
        case (timer_control_b[2:0])
            3'h0:    tick = 1'b0;
            3'h1:    tick = src_tick;
            3'h2:    tick = src_tick && (&presc[2:0]);
            3'h3:    tick = src_tick && (&presc[4:0]);
            3'h4:    tick = src_tick && (&presc[5:0]);
            3'h5:    tick = src_tick && (&presc[6:0]);
            3'h6:    tick = src_tick && (&presc[7:0]);
            default: tick = src_tick && (&presc[9:0]);
        endcase
    end

    // ==========================================================
    // counter, compare buffering and events
    wire logic match_a = count_value == compare_value_a;
    wire logic match_b = count_value == compare_value_b;
    wire logic at_top  = count_value == top;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value     <= 8'h00;
            count_up        <= 1'b1;
            block_match     <= 1'b0;
            compare_value_a <= 8'h00;
            compare_value_b <= 8'h00;
        end else begin
            // armed with the write itself, so the very next tick is covered
            if (do_wr && wr_addr == count_addr) begin
                block_match <= 1'b1;
            end else if (tick) begin
                block_match <= 1'b0;
            end
            // update point per mode
            if (kind != kind_phase && kind != kind_fast) begin
                compare_value_a <= buf_a;
                compare_value_b <= buf_b;
            end else if (tick && kind == kind_phase && at_top) begin
                compare_value_a <= buf_a;
                compare_value_b <= buf_b;
            end else if (tick && kind == kind_fast && count_value == count_bottom) begin
                compare_value_a <= buf_a;
                compare_value_b <= buf_b;
            end
            if (do_wr && wr_addr == count_addr) begin
                count_value <= wd;
            end else if (tick) begin
                if (kind == kind_phase) begin
                    if (count_up && at_top) begin
                        count_up    <= 1'b0;
                        count_value <= count_value - 1'b1;
                    end else if (!count_up && count_value == count_bottom) begin
                        count_up    <= 1'b1;
                        count_value <= count_value + 1'b1;
                    end else begin
                        count_value <= count_up ? count_value + 1'b1 : count_value - 1'b1;
                    end
                end else if (at_top && (kind == kind_fast || mode == mode_ctc)) begin
                    count_value <= count_bottom;
                end else begin
                    count_up    <= 1'b1;
                    count_value <= count_value + 1'b1;
                end
            end
        end
    end

    // force strobes do not reach these flags
    always_comb begin
        ev = 3'h0;
        if (tick) begin
            ev[irq_ma] = match_a && !block_match;
            ev[irq_mb] = match_b && !block_match;
            if (kind == kind_phase) begin
                ev[irq_ovf] = !count_up && count_value == count_bottom;
            end else if (mode == mode_fast_a) begin
                ev[irq_ovf] = at_top;
            end else begin
                ev[irq_ovf] = count_value == count_max;
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 3'h0;
        end else if (do_wr && wr_addr == irq_clear_addr) begin
            irq_status <= (irq_status & ~wd[2:0]) | ev;
        end else begin
            irq_status <= irq_status | ev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_status | ev) & irq_enable);
        end
    end

    // ==========================================================
    // waveform outputs, one generate per channel
    logic [1:0] wave;
    logic [1:0] oe;
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_wave
            wire logic [1:0] act  = ch == 0 ? timer_control_a[act_a_hi:act_a_lo]
                                            : timer_control_a[act_b_hi:act_b_lo];
            wire logic       mt   = ch == 0 ? match_a : match_b;
            wire logic [7:0] cv   = ch == 0 ? compare_value_a : compare_value_b;
            wire logic       frc  = ch == 0 ? force_a : force_b;
            wire logic       hit  = tick && mt && !block_match;
            wire logic       cvtop = cv == top;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    wave[ch] <= 1'b0;
                    oe[ch]   <= 1'b0;
                end else begin
                    oe[ch] <= act != act_off;
                    if (frc || (hit && kind == kind_plain_type_n)) begin
                        case (act)
                            act_toggle: wave[ch] <= !wave[ch];
                            act_clear:  wave[ch] <= 1'b0;
                            act_set:    wave[ch] <= 1'b1;
                            default:    wave[ch] <= wave[ch];
                        endcase
                    end else if (kind == kind_fast && act[1] && tick) begin
                        if (count_value == top) begin
                            wave[ch] <= !act[0];
                        end else if (mt && !block_match && !cvtop) begin
                            wave[ch] <= act[0];
                        end
                    end else if (kind == kind_phase && act[1] && tick) begin
                        if (cvtop && at_top) begin
                            wave[ch] <= act[0];
                        end else if (mt && !block_match && !cvtop) begin
                            wave[ch] <= count_up ? act[0] : !act[0];
                        end
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_out_a <= 1'b0;
            compare_out_b <= 1'b0;
            compare_oe_a  <= 1'b0;
            compare_oe_b  <= 1'b0;
        end else begin
            compare_out_a <= wave[0];
            compare_out_b <= wave[1];
            compare_oe_a  <= oe[0];
            compare_oe_b  <= oe[1];
        end
    end

    // ==========================================================
    // checks
    chk_force_no_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        force_a && !tick |=> !$rose(irq_status[irq_ma]))
        else $error("force strobe raised a flag");
    chk_force_pwm_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        (force_a || force_b) |-> $past(kind) == kind_plain_type_n)
        else $error("force strobe in pwm mode");
    chk_stop_clock: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_control_b[2:0] == 3'h0 && !count_wr && !do_wr |=> $stable(count_value))
        else $error("counter moved while stopped");
    chk_oe_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_control_a[act_b_hi:act_b_lo] != act_off [*3] |-> compare_oe_b)
        else $error("output b enable missing");
    chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (timer_control_a & ~ctrl_a_rd_mask) == 8'h00)
        else $error("reserved bit stored");
    chk_block_match: assert property (@(posedge hclk) disable iff (!hresetn)
        count_wr |-> !ev[irq_ma] && !ev[irq_mb])
        else $error("match not blocked after count write");
    chk_fast_bottom: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && kind == kind_fast && at_top && timer_control_a[act_b_hi:act_b_lo] == act_clear
        && !force_b |=> wave[1])
        else $error("fast pwm not set at bottom");
    chk_ovf_normal: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && mode == mode_normal && count_value == count_max |=> irq_status[irq_ovf])
        else $error("overflow flag not set at max");
    cov_toggle: cover property (@(posedge hclk) $changed(compare_out_b));
    cov_irq: cover property (@(posedge hclk) $rose(irq));
    cov_phase: cover property (@(posedge hclk) kind == kind_phase && $fell(count_up));
endmodule
`default_nettype wire

// ===== timer2_wave_clock_control_tb_top.sv
// Purpose: self-checking bench for the timer waveform and clock control block
// Assumes: AHB-Lite slave, registers in the low byte of each word
// Notes:   duty figures allow a few cycles for window phase against the PWM period and pin lag
`timescale 1ns/1ps
`default_nettype none
module timer2_wave_clock_control_tb_top;
    import timer_wave_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic        osc_pin;
    logic        osc_run;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] rd;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         out_a;
    wire         out_b;
    wire         oe_a;
    wire         oe_b;
    wire         irq;
    int          num_errors;
    int          total_checks;
    int          h;
    int          k;
    int          divs[7] = '{1, 8, 32, 64, 128, 256, 1024};
    logic [2:0]  pm[6]   = '{3'h3, 3'h3, 3'h1, 3'h1, 3'h7, 3'h7};
    logic [1:0]  pa[6]   = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h2};
    logic [7:0]  pca[6]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80};
    logic [7:0]  pcb[6]  = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h80, 8'h20};
    int          plo[6]  = '{125, 376, 122, 377, 508, 125};
    int          phi[6]  = '{134, 385, 133, 388, 510, 136};

    timer_wave_ctrl u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_pin(osc_pin),
        .compare_out_a(out_a), .compare_out_b(out_b), .compare_oe_a(oe_a),
        .compare_oe_b(oe_b), .irq(irq)
    );

    // ==========================================================
    // clock, oscillator pin, watchdog
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // oscillator stands still unless a test runs it
    initial begin
        forever begin
            repeat (5) @(posedge hclk);
            if (osc_run) osc_pin <= ~osc_pin;
        end
    end
    initial begin
        repeat (70000) @(posedge hclk);
        num_errors++;
        summarize();
    end

    // ==========================================================
    // bus and compare tasks
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, a, 2'h0};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic in_range(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic duty(input int n, output int hi_cnt);
        hi_cnt = 0;
        repeat (n) begin
            @(posedge hclk);
            if (out_b === 1'b1) hi_cnt++;
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // tests
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        osc_pin = 1'b0;
        osc_run = 1'b0;
        num_errors = 0;
        total_checks = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(ctrl_a_addr, 32'h0);
        rdc(ctrl_b_addr, 32'h0);
        wr(ctrl_a_addr, 32'hFC);
        rdc(ctrl_a_addr, 32'hF0);
        wr(ctrl_b_addr, 32'h30);
        rdc(ctrl_b_addr, 32'h0);
        wr(8'hE0, 32'h5A);
        rdc(8'hE0, 32'h0);
        $display("test registers done");
        // stopped counter, so only the strobes move the pins
        for (int i = 0; i < 3; i++) begin
            wr(ctrl_a_addr, {26'h0, 2'(i == 0 ? 1 : (i == 1 ? 3 : 2)), 4'h0});
            wr(ctrl_b_addr, 32'h40);
            tick(3);
            check({31'h0, out_b}, {31'h0, i != 2});
            check({31'h0, oe_b}, 32'h1);
        end
        rdc(ctrl_b_addr, 32'h0);
        rdc(irq_status_addr, 32'h0);
        wr(ctrl_a_addr, 32'hC0);
        wr(ctrl_b_addr, 32'h80);
        tick(3);
        check({31'h0, out_a}, 32'h1);
        wr(ctrl_a_addr, 32'h33);
        wr(ctrl_b_addr, 32'h40);
        tick(3);
        check({31'h0, out_b}, 32'h0);
        $display("test force done");
        for (int i = 0; i < 6; i++) begin
            wr(cmp_a_addr, {24'h0, pca[i]});
            wr(cmp_b_addr, {24'h0, pcb[i]});
            wr(ctrl_a_addr, {26'h0, pa[i], 2'h0, pm[i][1:0]});
            wr(ctrl_b_addr, {28'h0, pm[i][2], 3'h1});
            tick(600);
            duty(510, h);
            in_range(h, plo[i], phi[i]);
        end
        $display("test waveforms done");
        wr(ctrl_a_addr, 32'h0);
        for (int i = 0; i < 7; i++) begin
            wr(ctrl_b_addr, i + 1);
            wr(count_addr, 32'h0);
            tick(divs[i] * 20);
            bus(1'b0, count_addr, 32'h0, rd);
            in_range(int'(rd[7:0]), 19, 24);
        end
        wr(ctrl_b_addr, 32'h0);
        wr(count_addr, 32'h33);
        tick(50);
        rdc(count_addr, 32'h33);
        $display("test prescaler done");
        wr(src_sel_addr, 32'h1);
        osc_run <= 1'b1;
        wr(ctrl_b_addr, 32'h1);
        wr(count_addr, 32'h0);
        tick(200);
        bus(1'b0, count_addr, 32'h0, rd);
        in_range(int'(rd[7:0]), 16, 22);
        osc_run <= 1'b0;
        wr(src_sel_addr, 32'h0);
        $display("test source clock done");
        // counter parked on compare B, then started: first match is swallowed
        wr(ctrl_b_addr, 32'h0);
        wr(cmp_b_addr, 32'h50);
        wr(count_addr, 32'h50);
        wr(irq_clear_addr, 32'h7);
        wr(ctrl_b_addr, 32'h1);
        tick(20);
        bus(1'b0, irq_status_addr, 32'h0, rd);
        check({31'h0, rd[irq_mb]}, 32'h0);
        tick(300);
        bus(1'b0, irq_status_addr, 32'h0, rd);
        check({31'h0, rd[irq_mb]}, 32'h1);
        $display("test count write done");
        wr(irq_clear_addr, 32'h7);
        wr(irq_enable_addr, 32'h1);
        wr(count_addr, 32'hF0);
        for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        bus(1'b0, irq_status_addr, 32'h0, rd);
        check({31'h0, rd[0]}, 32'h1);
        wr(irq_clear_addr, 32'h7);
        tick(2);
        check({31'h0, irq}, 32'h0);
        bus(1'b0, irq_status_addr, 32'h0, rd);
        check({31'h0, rd[0]}, 32'h0);
        wr(irq_enable_addr, 32'h0);
        tick(300);
        check({31'h0, irq}, 32'h0);
        bus(1'b0, irq_status_addr, 32'h0, rd);
        check({31'h0, rd[0]}, 32'h1);
        $display("test interrupt done");
        summarize();
    end
endmodule
`default_nettype wire
